// ===== design/ebw_consts.svh
// constants for the external bus and wait-state block
`ifndef EBW_CONSTS_SVH
`define EBW_CONSTS_SVH

`define EBW_ADDR_W 16
`define EBW_DATA_W 16
`define EBW_WSC_W 4
`define EBW_WSC_ADDR 16'hffff
`define EBW_WSC_RESET 4'hf
`define EBW_BIT_PROG_WAIT 0
`define EBW_BIT_DATA_WAIT 1
`define EBW_BIT_IO_WAIT 2
`define EBW_BIT_TRACE 3
`define EBW_DATA_EXT_BASE 16'h8000
`define EBW_CLK_NS 10
`define EBW_MC_HALF_NS 10
`define EBW_MC_HALF_CLKS ((`EBW_MC_HALF_NS + `EBW_CLK_NS - 1) / `EBW_CLK_NS)

`endif

// ===== design/ebw_pkg.sv
// types shared by the external bus block
package ebw_pkg;
    typedef enum logic [1:0] {
        EBW_SP_PROG = 2'h0,
        EBW_SP_DATA = 2'h1,
        EBW_SP_IO = 2'h2
    } ebw_space_t;

    typedef enum logic [3:0] {
        EBW_S_IDLE = 4'h1,
        EBW_S_SETUP = 4'h2,
        EBW_S_ACT = 4'h4,
        EBW_S_HOLD = 4'h8
    } ebw_state_t;
endpackage

// ===== design/ebw_cfg_if.sv
// link between bus sequencer and wait-state control register
`timescale 1ns/1ps
`default_nettype none
interface ebw_cfg_if;
    logic wr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic trace_en;
    logic io_wait;
    logic data_wait;
    logic prog_wait;

    modport reg_side (
        input wr,
        input wdata,
        output rdata,
        output trace_en,
        output io_wait,
        output data_wait,
        output prog_wait
    );

    modport user (
        output wr,
        output wdata,
        input rdata,
        input trace_en,
        input io_wait,
        input data_wait,
        input prog_wait
    );
endinterface
`default_nettype wire

// ===== design/ebw_wait_ctrl.sv
// wait-state control register
`timescale 1ns/1ps
`default_nettype none
`include "ebw_consts.svh"
module ebw_wait_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    ebw_cfg_if.reg_side cfg
);
    import ebw_pkg::*;

    logic [`EBW_WSC_W-1:0] wsc;
    logic seen_wr;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wsc <= `EBW_WSC_RESET;
        end else if (cfg.wr) begin
            wsc <= cfg.wdata[`EBW_WSC_W-1:0];
        end
    end

    // upper bits read as zero
    assign cfg.rdata = {{(16 - `EBW_WSC_W){1'b0}}, wsc};
    assign cfg.trace_en = wsc[`EBW_BIT_TRACE];
    assign cfg.io_wait = wsc[`EBW_BIT_IO_WAIT];
    assign cfg.data_wait = wsc[`EBW_BIT_DATA_WAIT];
    assign cfg.prog_wait = wsc[`EBW_BIT_PROG_WAIT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_wr <= 1'b0;
        end else if (cfg.wr) begin
            seen_wr <= 1'b1;
        end
    end

    AST_RESET_ALL_SET: assert property (@(posedge clk)
        disable iff (!rst_n)
        !seen_wr |-> (cfg.rdata == 16'h000f))
        else $error("wait control not all ones after reset");
    AST_RESV_ZERO: assert property (@(posedge clk)
        disable iff (!rst_n)
        cfg.wr |=> (cfg.rdata[15:4] == 12'h000))
        else $error("reserved bits read non-zero");
    AST_WR_TAKES: assert property (@(posedge clk)
        disable iff (!rst_n)
        cfg.wr |=> (cfg.rdata[3:0] == $past(cfg.wdata[3:0])))
        else $error("control write not stored");
endmodule
`default_nettype wire

// ===== design/ebw_ext_bus.sv
// external bus sequencer with wait-state insertion
`timescale 1ns/1ps
`default_nettype none
`include "ebw_consts.svh"
module ebw_ext_bus #(
    parameter int HALF_CLKS = `EBW_MC_HALF_CLKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic core_req,
    input wire ebw_pkg::ebw_space_t core_space,
    input wire logic [15:0] core_addr,
    input wire logic [15:0] core_wdata,
    input wire logic core_write,
    input wire logic core_prog_ext,
    input wire logic [15:0] core_pc,
    output logic [15:0] core_rdata,
    output logic core_ack,
    output logic machine_clock,
    output logic [15:0] addr_o,
    output logic addr_oe,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic data_oe,
    output logic program_select_n,
    output logic data_select_n,
    output logic io_select_n,
    output logic access_strobe_n,
    output logic write_enable_n,
    output logic read_not_write,
    output logic write_not_read,
    input wire logic ready
);
    import ebw_pkg::*;

    localparam int DIV_W = (HALF_CLKS > 1) ? $clog2(HALF_CLKS) : 1;

    ebw_cfg_if cfg ();

    ebw_wait_ctrl u_wait_ctrl (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(cfg)
    );

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic ready_m;
    logic ready_s;
    logic [15:0] data_m;
    logic [15:0] data_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_m <= 1'b1;
            ready_s <= 1'b1;
            data_m <= 16'h0000;
            data_s <= 16'h0000;
        end else begin
            ready_m <= ready;
            ready_s <= ready_m;
            data_m <= data_i;
            data_s <= data_m;
        end
    end

    // ****************************************
    // machine clock divider
    // ****************************************
    logic [DIV_W-1:0] div_cnt;
    logic tick;
    logic boundary;

    assign tick = (div_cnt == DIV_W'(HALF_CLKS - 1));
    assign boundary = tick && machine_clock;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
        end else if (tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            machine_clock <= 1'b0;
        end else if (tick) begin
            machine_clock <= ~machine_clock;
        end
    end

    // ****************************************
    // request decode
    // ****************************************
    logic is_wsc;
    logic is_ext;
    logic wait_bit;
    logic take;
    logic start_ext;
    logic start_int;
    ebw_state_t state;
    logic rd_pend;

    assign is_wsc = (core_space == EBW_SP_IO)
        && (core_addr == `EBW_WSC_ADDR);

    always_comb begin
        is_ext = 1'b0;
        wait_bit = 1'b0;
        unique case (core_space)
            EBW_SP_PROG: begin
                is_ext = core_prog_ext;
                wait_bit = cfg.prog_wait;
            end
            EBW_SP_DATA: begin
                is_ext = (core_addr >= `EBW_DATA_EXT_BASE);
                wait_bit = cfg.data_wait;
            end
            EBW_SP_IO: begin
                is_ext = !is_wsc;
                wait_bit = cfg.io_wait;
            end
            default: begin
                is_ext = 1'b0;
                wait_bit = 1'b0;
            end
        endcase
    end

    // a read answered one clk late must not be taken twice
    assign take = (state == EBW_S_IDLE) && core_req && !core_ack
        && !rd_pend;
    // external cycles open on a machine-cycle edge only
    assign start_ext = take && is_ext && boundary;
    assign start_int = take && !is_ext;

    assign cfg.wr = start_int && is_wsc && core_write;
    assign cfg.wdata = core_wdata;

    // ****************************************
    // bus cycle sequencer
    // ****************************************
    logic hcnt;
    logic pw;
    logic acc_write;
    ebw_space_t acc_space;
    logic [15:0] acc_addr;
    logic act_end;
    logic done;

    assign act_end = (state == EBW_S_ACT) && tick && hcnt;
    assign done = (act_end && !pw && ready_s && !acc_write)
        || ((state == EBW_S_HOLD) && tick);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= EBW_S_IDLE;
            hcnt <= 1'b0;
            pw <= 1'b0;
            acc_write <= 1'b0;
            acc_space <= EBW_SP_PROG;
            acc_addr <= 16'h0000;
            data_o <= 16'h0000;
        end else begin
            unique case (state)
                EBW_S_IDLE: begin
                    if (start_ext) begin
                        acc_write <= core_write;
                        acc_space <= core_space;
                        acc_addr <= core_addr;
                        data_o <= core_wdata;
                        pw <= wait_bit;
                        hcnt <= 1'b0;
                        // write gets a half cycle of strobe before write enable
                        state <= core_write ? EBW_S_SETUP : EBW_S_ACT;
                    end
                end
                EBW_S_SETUP: begin
                    if (tick) begin
                        state <= EBW_S_ACT;
                    end
                end
                EBW_S_ACT: begin
                    if (tick) begin
                        hcnt <= ~hcnt;
                        if (hcnt) begin
                            if (pw) begin
                                pw <= 1'b0;
                            end else if (ready_s) begin
                                state <= acc_write ? EBW_S_HOLD
                                    : EBW_S_IDLE;
                            end
                        end
                    end
                end
                EBW_S_HOLD: begin
                    if (tick) begin
                        state <= EBW_S_IDLE;
                    end
                end
                default: begin
                    state <= EBW_S_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // core answer
    // ****************************************
    // data_s lags the pins two clks: answer reads one clk after strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend <= 1'b0;
        end else begin
            rd_pend <= done && !acc_write;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_ack <= 1'b0;
        end else begin
            core_ack <= start_int || (done && acc_write) || rd_pend;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_rdata <= 16'h0000;
        end else if (start_int) begin
            core_rdata <= is_wsc ? cfg.rdata : 16'h0000;
        end else if (rd_pend) begin
            core_rdata <= data_s;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    logic busy;
    logic [15:0] pc_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= 16'h0000;
        end else begin
            pc_q <= core_pc;
        end
    end

    assign busy = (state != EBW_S_IDLE);
    assign addr_oe = busy || cfg.trace_en;
    assign addr_o = busy ? acc_addr : pc_q;
    assign data_oe = busy && acc_write;
    assign program_select_n = !(busy && acc_space == EBW_SP_PROG);
    assign data_select_n = !(busy && acc_space == EBW_SP_DATA);
    assign io_select_n = !(busy && acc_space == EBW_SP_IO);
    assign access_strobe_n = !busy;
    assign write_enable_n = !((state == EBW_S_ACT) && acc_write);
    assign read_not_write = !(busy && acc_write);
    assign write_not_read = busy && acc_write;

    // ****************************************
    // checks
    // ****************************************
    AST_ONE_SELECT: assert property (@(posedge clk)
        disable iff (!rst_n)
        $onehot0({~program_select_n, ~data_select_n, ~io_select_n}))
        else $error("more than one space select active");
    AST_STROBE_SEL: assert property (@(posedge clk)
        disable iff (!rst_n)
        !access_strobe_n == !(program_select_n && data_select_n
        && io_select_n))
        else $error("strobe and selects disagree");
    AST_WE_SETUP: assert property (@(posedge clk)
        disable iff (!rst_n)
        $fell(write_enable_n) |-> $past(data_oe) && $past(!access_strobe_n))
        else $error("write enable fell without setup half");
    AST_WE_HOLD: assert property (@(posedge clk)
        disable iff (!rst_n)
        $rose(write_enable_n) && data_oe |-> !access_strobe_n
        && (state == EBW_S_HOLD))
        else $error("no hold half after write enable");
    AST_READY_STALL: assert property (@(posedge clk)
        disable iff (!rst_n)
        act_end && !pw && !ready_s |=> (state == EBW_S_ACT) && !core_ack)
        else $error("cycle ended while ready low");
    AST_PW_STALL: assert property (@(posedge clk)
        disable iff (!rst_n)
        act_end && pw |=> (state == EBW_S_ACT) && !pw)
        else $error("programmed wait not inserted");
    AST_PW_LOAD: assert property (@(posedge clk)
        disable iff (!rst_n)
        start_ext |=> (pw == $past(wait_bit)))
        else $error("wait bit not applied to access");
    AST_IDLE_QUIET: assert property (@(posedge clk)
        disable iff (!rst_n)
        !busy && !cfg.trace_en |-> !addr_oe && !data_oe && access_strobe_n)
        else $error("bus driven while idle");
    AST_ONCHIP_QUIET: assert property (@(posedge clk)
        disable iff (!rst_n)
        start_int |=> access_strobe_n && core_ack)
        else $error("on-chip access touched external bus");
    AST_RNW_PAIR: assert property (@(posedge clk)
        disable iff (!rst_n)
        !access_strobe_n |-> (read_not_write == !write_not_read))
        else $error("direction outputs not complementary");
    AST_ONE_WAIT: assert property (@(posedge clk)
        disable iff (!rst_n)
        busy && !pw |=> !pw)
        else $error("second programmed wait in one access");
    AST_TRACE_PC: assert property (@(posedge clk)
        disable iff (!rst_n)
        !busy && cfg.trace_en |-> addr_oe && (addr_o == pc_q))
        else $error("idle bus not showing program address");
    AST_RD_ONCE: assert property (@(posedge clk)
        disable iff (!rst_n)
        rd_pend |-> !start_ext && !start_int)
        else $error("read taken again before its answer");
    AST_RD_ANSWER: assert property (@(posedge clk)
        disable iff (!rst_n)
        rd_pend |=> core_ack && (core_rdata == $past(data_s)))
        else $error("read answer missing");
    AST_PROG_ONCHIP: assert property (@(posedge clk)
        disable iff (!rst_n)
        start_int && (core_space == EBW_SP_PROG) |=> program_select_n)
        else $error("program select on on-chip access");
endmodule
`default_nettype wire

// ===== sim/ebw_mem_model.sv
// external memory model on the far side of the bus block
`timescale 1ns/1ps
`default_nettype none
module ebw_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] addr_o,
    input wire logic [15:0] data_o,
    input wire logic data_oe,
    input wire logic access_strobe_n,
    input wire logic write_enable_n,
    input wire logic write_not_read,
    input wire logic [7:0] stall_clks,
    output logic [15:0] data_i,
    output logic ready
);
    logic [15:0] mem [0:63];
    logic [15:0] last;
    logic [7:0] cnt;
    logic access_strobe_n_q;
    logic rd_on;
    assign rd_on = !access_strobe_n && !write_not_read && !data_oe;
    // released bus shows the inverse of the last word
    assign data_i = rd_on ? mem[addr_o[5:0]] : ~last;
    assign ready = (cnt == 8'h00);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last <= 16'h0000;
            cnt <= 8'h00;
            access_strobe_n_q <= 1'b1;
        end else begin
            access_strobe_n_q <= access_strobe_n;
            if (rd_on) begin
                last <= data_i;
            end
            if (!write_enable_n && data_oe) begin
                mem[addr_o[5:0]] <= data_o;
            end
            // stall starts after the first cycle only
            if (access_strobe_n_q && !access_strobe_n) begin
                cnt <= stall_clks;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ===== sim/ebw_ext_bus_test.sv
// self-checking bench for the external bus block
`timescale 1ns/1ps
`default_nettype none
module ebw_ext_bus_test;
    import ebw_pkg::*;
    logic clk, rst_n, core_req, core_write, core_prog_ext, core_ack;
    ebw_space_t core_space;
    logic [15:0] core_addr, core_wdata, core_pc, core_rdata;
    logic [15:0] addr_o, data_i, data_o;
    logic machine_clock, addr_oe, data_oe, ready;
    logic program_select_n, data_select_n, io_select_n;
    logic access_strobe_n, write_enable_n, read_not_write, write_not_read;
    logic [7:0] stall_clks;
    logic [2:0] sel_seen;
    logic [1:0] rw_seen;
    logic we_first, we_last, mc_seen, oe_seen;
    logic [15:0] adr_seen, rd;
    logic [15:0] base [3] = '{16'h0010, 16'h8000, 16'h0030};
    logic [15:0] sel_exp [3] = '{16'h0003, 16'h0005, 16'h0006};
    int str_n, n_checks = 0, n_mismatch = 0, cyc = 0;
    ebw_ext_bus #(.HALF_CLKS(1)) dut_u (.clk(clk), .rst_n(rst_n),
        .core_req(core_req), .core_space(core_space),
        .core_addr(core_addr), .core_wdata(core_wdata),
        .core_write(core_write), .core_prog_ext(core_prog_ext),
        .core_pc(core_pc), .core_rdata(core_rdata), .core_ack(core_ack),
        .machine_clock(machine_clock), .addr_o(addr_o),
        .addr_oe(addr_oe), .data_i(data_i), .data_o(data_o),
        .data_oe(data_oe), .program_select_n(program_select_n),
        .data_select_n(data_select_n), .io_select_n(io_select_n),
        .access_strobe_n(access_strobe_n),
        .write_enable_n(write_enable_n), .read_not_write(read_not_write),
        .write_not_read(write_not_read), .ready(ready));
    ebw_mem_model mem_u (.clk(clk), .rst_n(rst_n), .addr_o(addr_o),
        .data_o(data_o), .data_oe(data_oe),
        .access_strobe_n(access_strobe_n),
        .write_enable_n(write_enable_n), .write_not_read(write_not_read),
        .stall_clks(stall_clks), .data_i(data_i), .ready(ready));
    // ***************
    // tasks
    // ***************
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one core access; records what the pins showed
    task automatic xfer(input int sp, input logic [15:0] a,
            input logic wr, input logic ext, input logic [15:0] wd);
        int n;
        @(posedge clk);
        core_req <= 1'b1;
        core_space <= ebw_space_t'(sp[1:0]);
        core_addr <= a;
        core_write <= wr;
        core_prog_ext <= ext;
        core_wdata <= wd;
        str_n = 0;
        for (n = 0; n < 200 && core_ack !== 1'b1; n++) begin
            @(posedge clk);
            #1;
            if (access_strobe_n === 1'b0) begin
                if (str_n == 0) begin
                    sel_seen = {program_select_n, data_select_n, io_select_n};
                    we_first = write_enable_n;
                    adr_seen = addr_o;
                    rw_seen = {read_not_write, write_not_read};
                    mc_seen = machine_clock;
                    oe_seen = data_oe;
                end
                str_n++;
                we_last = write_enable_n;
            end
        end
        if (n == 200) begin
            n_mismatch++;
            $display("mismatch at %0t: no acknowledge", $time);
        end
        rd = core_rdata;
        @(posedge clk);
        core_req <= 1'b0;
    endtask
    // ***************
    // clock, limit, tests
    // ***************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        rst_n = 1'b0;
        core_req = 1'b0;
        core_space = EBW_SP_PROG;
        core_addr = 16'h0000;
        core_wdata = 16'h0000;
        core_write = 1'b0;
        core_prog_ext = 1'b0;
        core_pc = 16'h1234;
        stall_clks = 8'h00;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        xfer(2, 16'hffff, 0, 0, 16'h0000);
        chk(rd, 16'h000f);
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0, addr_oe}, 16'h0001);
        chk(addr_o, 16'h1234);
        for (int w = 0; w < 2; w++) begin
            for (int s = 0; s < 3; s++) begin
                xfer(2, 16'hffff, 1, 0, 16'hfff0 | 16'(w << s));
                xfer(s, base[s], 1, 1, 16'ha5c0 + 16'(s + w * 16));
                chk(16'(str_n), 16'(4 + 2 * w));
                chk({14'h0, we_first, we_last}, 16'h0003);
                chk({13'h0, sel_seen}, sel_exp[s]);
                chk({14'h0, rw_seen}, 16'h0001);
                chk(adr_seen, base[s]);
                chk({14'h0, mc_seen, oe_seen}, 16'h0001);
                xfer(s, base[s], 0, 1, 16'h0000);
                chk(16'(str_n), 16'(2 + 2 * w));
                chk(rd, 16'ha5c0 + 16'(s + w * 16));
                chk({14'h0, rw_seen}, 16'h0002);
                chk({14'h0, mc_seen, oe_seen}, 16'h0000);
            end
        end
        xfer(2, 16'hffff, 0, 0, 16'h0000);
        chk(rd, 16'h0004);
        #1;
        chk({15'h0, addr_oe}, 16'h0000);
        xfer(1, 16'h7fff, 0, 0, 16'h0000);
        chk(16'(str_n), 16'h0000);
        xfer(0, 16'h0010, 0, 0, 16'h0000);
        chk(16'(str_n), 16'h0000);
        xfer(2, 16'hffff, 1, 0, 16'h0002);
        stall_clks <= 8'h08;
        xfer(1, 16'h8000, 0, 1, 16'h0000);
        chk({15'h0, 1'(str_n > 4 && str_n <= 16)}, 16'h0001);
        chk(rd, 16'ha5d1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0, access_strobe_n}, 16'h0001);
        chk({14'h0, machine_clock, write_enable_n}, 16'h0001);
        @(posedge clk);
        rst_n <= 1'b1;
        xfer(2, 16'hffff, 0, 0, 16'h0000);
        chk(rd, 16'h000f);
        close_out();
    end
endmodule
`default_nettype wire
